/* hdl/eeprom_pkg.sv */
// constants and types shared by the serial memory slave port
package eeprom_pkg;
  // ************************************************************
  // geometry
  // ************************************************************
  localparam int         MEM_BYTES    = 128;
  localparam int         ADDR_W       = 7;
  localparam int         DATA_W       = 8;
  localparam int         FIFO_DEPTH   = 32;
  localparam logic [4:0] BLOCK_BYTES  = 5'h10;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [3:0] ACK_BITS     = 4'h9;
  localparam logic [3:0] DEV_TYPE_DEF = 4'h5;   // arbitrary value
  localparam logic [2:0] BUS_ADDR     = 3'h0;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_NS       = 25;
  localparam int PROG_BYTE_NS = 1000;           // programming time per byte
  localparam int PROG_CYC     = (PROG_BYTE_NS + CLK_NS - 1) / CLK_NS;
  // ************************************************************
  // reset values and states
  // ************************************************************
  localparam logic [6:0] PTR_RST = 7'h00;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_ACK  = 6'h04,
    ST_TX   = 6'h08,
    ST_MACK = 6'h10,
    ST_PROG = 6'h20
  } state_t;
  typedef enum logic [1:0] {
    PH_DEV  = 2'h0,
    PH_ADDR = 2'h1,
    PH_DATA = 2'h2
  } phase_t;
endpackage : eeprom_pkg

/* hdl/sync_2ff.sv */
// two flip-flop synchroniser for a group of independent levels
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sync_2ff

/* hdl/fifo_buf.sv */
// synchronous first-in first-out buffer with valid/ready on both sides
module fifo_buf #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  // honest flags from the fill count
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    next_wr_ptr = wr_ptr + AW'(push);
    next_rd_ptr = rd_ptr + AW'(pop);
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage array, not reset
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end
endmodule : fifo_buf

/* hdl/eeprom_serial_port.sv */
// two-wire slave port of a 128-byte non-volatile memory
// Operation
// - data out follows data in, except while this port pulls it low
// - START is data falling while clock is high; precedes every command
// - watch for START always except while programming; ignore bus until then
// - STOP is data rising while clock is high; it ends the exchange
// - STOP after a write starts the programming cycle
// - incoming bits are sampled on rising clock edges
// - whole bytes, most significant bit first
// - transmitter releases after eight bits; receiver pulls low on ninth
// - addressing byte: type code, bus address zero, direction; we acknowledge
// - write: address byte then data bytes, each stored and acknowledged until STOP
// - at most 16 bytes per access before re-addressing
// - read: set pointer, repeated START, read addressing byte, then data out
// - 128 bytes of storage reachable over the port
module eeprom_serial_port #(
  parameter logic [3:0] DEV_TYPE   = eeprom_pkg::DEV_TYPE_DEF,  // arbitrary value
  parameter int         PROG_CYC   = eeprom_pkg::PROG_CYC,
  parameter int         FIFO_DEPTH = eeprom_pkg::FIFO_DEPTH
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic link_clk,
  input  wire logic data_in,
  output logic      data_out,
  output logic      prog_busy
);
  localparam int TW = $clog2(PROG_CYC + 1);
  localparam int FW = eeprom_pkg::ADDR_W + eeprom_pkg::DATA_W;
  if (PROG_CYC < 1 || PROG_CYC > 4096) begin : g_bad_prog
    $error("programming cycle count out of range");
  end
  // ************************************************************
  // link clock domain
  // ************************************************************
  logic link_bit, next_link_bit;
  // data captured on each rising link clock edge
  always_comb begin
    next_link_bit = data_in;
  end
  always_ff @(posedge link_clk) begin
    link_bit <= next_link_bit;
  end
  // ************************************************************
  // crossing and line events
  // ************************************************************
  logic [2:0] sync_q;
  logic       bit_s, sda_s, scl_s;
  logic       scl_prev, sda_prev, rise_d;
  logic       next_scl_prev, next_sda_prev, next_rise_d;
  logic       rise, fall, start, stop;
  sync_2ff #(.W(3)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({link_bit, data_in, link_clk}),
    .q     (sync_q)
  );
  assign bit_s = sync_q[2];
  assign sda_s = sync_q[1];
  assign scl_s = sync_q[0];
  assign rise  = scl_s & ~scl_prev;
  assign fall  = ~scl_s & scl_prev;
  assign start = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop  = scl_s & scl_prev & ~sda_prev & sda_s;
  // previous levels; sampled bit is read one cycle after the rise
  always_comb begin
    next_scl_prev = scl_s;
    next_sda_prev = sda_s;
    next_rise_d   = rise;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      rise_d   <= 1'b0;
    end else begin
      scl_prev <= next_scl_prev;
      sda_prev <= next_sda_prev;
      rise_d   <= next_rise_d;
    end
  end

  // ************************************************************
  // storage and write buffer
  // ************************************************************
  logic [7:0]    mem [eeprom_pkg::MEM_BYTES];
  logic          push_valid, push_ready, pop_valid, pop_ready;
  logic [FW-1:0] pop_data;
  logic [6:0]    ptr, next_ptr;
  logic [7:0]    shift, next_shift;

  fifo_buf #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   ({ptr, shift}),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_data)
  );

  // programming writes one buffered byte per cycle slot
  always_ff @(posedge clk) begin
    if (pop_valid && pop_ready) begin
      mem[pop_data[FW-1:8]] <= pop_data[7:0];
    end
  end

  // ************************************************************
  // protocol engine
  // ************************************************************
  eeprom_pkg::state_t state, next_state;
  eeprom_pkg::phase_t phase, next_phase;
  logic          rd_mode, next_rd_mode, pull, next_pull, mack, next_mack;
  logic          wr_pending, next_wr_pending, next_data_out, next_prog_busy;
  logic [3:0]    bit_cnt, next_bit_cnt;
  logic [4:0]    byte_cnt, next_byte_cnt;
  logic [TW-1:0] timer, next_timer;
  logic          ack, ptr_inc;
  // next state of the engine
  always_comb begin
    next_state      = state;
    next_phase      = phase;
    next_rd_mode    = rd_mode;
    next_pull       = pull;
    next_mack       = mack;
    next_wr_pending = wr_pending;
    next_bit_cnt    = bit_cnt;
    next_byte_cnt   = byte_cnt;
    next_timer      = timer;
    next_shift      = shift;
    next_ptr        = ptr;
    push_valid      = 1'b0;
    pop_ready       = 1'b0;
    ack             = 1'b0;
    ptr_inc         = 1'b0;
    case (state)
      eeprom_pkg::ST_IDLE: begin
      end
      eeprom_pkg::ST_RX: begin
        if (rise_d) begin
          next_shift   = {shift[6:0], bit_s};
          next_bit_cnt = bit_cnt + 4'h1;
        end else if (fall && bit_cnt == eeprom_pkg::BYTE_BITS) begin
          case (phase)
            eeprom_pkg::PH_DEV: begin
              if (shift[7:1] == {DEV_TYPE, eeprom_pkg::BUS_ADDR}) begin
                ack           = 1'b1;
                next_rd_mode  = shift[0];
                next_byte_cnt = 5'h00;
              end
            end
            eeprom_pkg::PH_ADDR: begin
              ack      = 1'b1;
              next_ptr = shift[6:0];
            end
            default: begin
              if (byte_cnt < eeprom_pkg::BLOCK_BYTES && push_ready) begin
                ack             = 1'b1;
                push_valid      = 1'b1;
                ptr_inc         = 1'b1;
                next_byte_cnt   = byte_cnt + 5'h01;
                next_wr_pending = 1'b1;
              end
            end
          endcase
          next_pull  = ack;
          next_state = ack ? eeprom_pkg::ST_ACK : eeprom_pkg::ST_IDLE;
        end
      end
      eeprom_pkg::ST_ACK: begin
        if (rise_d) begin
          next_bit_cnt = eeprom_pkg::ACK_BITS;
        end else if (fall && bit_cnt == eeprom_pkg::ACK_BITS) begin
          next_bit_cnt = 4'h0;
          next_pull    = 1'b0;
          if (rd_mode) begin
            next_shift = mem[ptr];
            next_pull  = ~mem[ptr][7];
            next_state = eeprom_pkg::ST_TX;
          end else begin
            next_phase = (phase == eeprom_pkg::PH_DEV) ? eeprom_pkg::PH_ADDR : eeprom_pkg::PH_DATA;
            next_state = eeprom_pkg::ST_RX;
          end
        end
      end
      eeprom_pkg::ST_TX: begin
        if (rise_d) begin
          next_bit_cnt = bit_cnt + 4'h1;
        end else if (fall) begin
          if (bit_cnt == eeprom_pkg::BYTE_BITS) begin
            next_pull     = 1'b0;
            ptr_inc       = 1'b1;
            next_byte_cnt = byte_cnt + 5'h01;
            next_state    = eeprom_pkg::ST_MACK;
          end else begin
            next_shift = {shift[6:0], 1'b0};
            next_pull  = ~shift[6];
          end
        end
      end
      eeprom_pkg::ST_MACK: begin
        if (rise_d) begin
          next_mack    = bit_s;
          next_bit_cnt = eeprom_pkg::ACK_BITS;
        end else if (fall && bit_cnt == eeprom_pkg::ACK_BITS) begin
          next_bit_cnt = 4'h0;
          if (!mack && byte_cnt < eeprom_pkg::BLOCK_BYTES) begin
            next_shift = mem[ptr];
            next_pull  = ~mem[ptr][7];
            next_state = eeprom_pkg::ST_TX;
          end else begin
            next_state = eeprom_pkg::ST_IDLE;
          end
        end
      end
      eeprom_pkg::ST_PROG: begin
        if (timer != '0) begin
          next_timer = timer - TW'(1);
        end else if (pop_valid) begin
          pop_ready  = 1'b1;
          next_timer = TW'(PROG_CYC);
        end else begin
          next_wr_pending = 1'b0;
          next_state      = eeprom_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = eeprom_pkg::ST_IDLE;
      end
    endcase
    if (ptr_inc) begin
      next_ptr = {ptr[6:4], ptr[3:0] + 4'h1};
    end
    if (state != eeprom_pkg::ST_PROG) begin
      if (stop) begin
        next_pull  = 1'b0;
        next_timer = '0;
        next_state = wr_pending ? eeprom_pkg::ST_PROG : eeprom_pkg::ST_IDLE;
      end else if (start) begin
        next_pull     = 1'b0;
        next_bit_cnt  = 4'h0;
        next_byte_cnt = 5'h00;
        next_rd_mode  = 1'b0;
        next_phase    = eeprom_pkg::PH_DEV;
        next_state    = eeprom_pkg::ST_RX;
      end
    end
    next_data_out  = sda_s & ~next_pull;
    next_prog_busy = (next_state == eeprom_pkg::ST_PROG);
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= eeprom_pkg::ST_IDLE;
      phase      <= eeprom_pkg::PH_DEV;
      rd_mode    <= 1'b0;
      pull       <= 1'b0;
      mack       <= 1'b1;
      wr_pending <= 1'b0;
      bit_cnt    <= 4'h0;
      byte_cnt   <= 5'h00;
      timer      <= '0;
      shift      <= 8'h00;
      ptr        <= eeprom_pkg::PTR_RST;
      data_out   <= 1'b1;
      prog_busy  <= 1'b0;
    end else begin
      state      <= next_state;
      phase      <= next_phase;
      rd_mode    <= next_rd_mode;
      pull       <= next_pull;
      mack       <= next_mack;
      wr_pending <= next_wr_pending;
      bit_cnt    <= next_bit_cnt;
      byte_cnt   <= next_byte_cnt;
      timer      <= next_timer;
      shift      <= next_shift;
      ptr        <= next_ptr;
      data_out   <= next_data_out;
      prog_busy  <= next_prog_busy;
    end
  end
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_dev_match;
    state == eeprom_pkg::ST_RX && fall && bit_cnt == eeprom_pkg::BYTE_BITS &&
      phase == eeprom_pkg::PH_DEV && shift[7:1] == {DEV_TYPE, eeprom_pkg::BUS_ADDR};
  endsequence
  sequence s_ack_driven;
    state == eeprom_pkg::ST_ACK && data_out == 1'b0;
  endsequence
  property p_dev_ack;
    s_dev_match |=> s_ack_driven;
  endproperty
  a_dev_ack: assert property (p_dev_ack) else $error("addressing byte not acknowledged");
  property p_echo;
    !next_pull |=> data_out == $past(sda_s);
  endproperty
  a_echo: assert property (p_echo) else $error("data out does not follow data in");
  property p_prog_deaf;
    state == eeprom_pkg::ST_PROG && start && timer != '0 |=> state == eeprom_pkg::ST_PROG;
  endproperty
  a_prog_deaf: assert property (p_prog_deaf) else $error("start taken while programming");
  property p_stop_prog;
    state != eeprom_pkg::ST_PROG && stop && wr_pending |=> state == eeprom_pkg::ST_PROG && prog_busy;
  endproperty
  a_stop_prog: assert property (p_stop_prog) else $error("stop after write did not program");
  property p_start_rx;
    state != eeprom_pkg::ST_PROG && start && !stop |=> state == eeprom_pkg::ST_RX && bit_cnt == 4'h0;
  endproperty
  a_start_rx: assert property (p_start_rx) else $error("start not recognised");
  property p_shift_in;
    state == eeprom_pkg::ST_RX && rise_d && !start && !stop |=> shift[0] == $past(bit_s);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("sampled bit not shifted in");
  property p_wrap;
    ptr_inc |=> ptr[6:4] == $past(ptr[6:4]) && ptr[3:0] == $past(ptr[3:0]) + 4'h1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer step wrong");
  property p_limit;
    byte_cnt <= eeprom_pkg::BLOCK_BYTES;
  endproperty
  a_limit: assert property (p_limit) else $error("more than a block in one access");
  property p_tx_release;
    state == eeprom_pkg::ST_TX && fall && bit_cnt == eeprom_pkg::BYTE_BITS && !start && !stop
      |=> data_out == $past(sda_s) ##1 state == eeprom_pkg::ST_MACK;
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("line not released for acknowledge");
endmodule : eeprom_serial_port

/* tb/link_master.sv */
// bus master model that clocks the two-wire link and drives its data line
module link_master #(
  parameter int HALF_NS = 80
) (
  output logic      link_clk,
  output logic      data_in,
  input  wire logic data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // idle levels
  // ************************************************************
  // clock and data stand high between frames; the master alone drives the clock
  initial begin
    link_clk = 1'b1;
    data_in  = 1'b1;
  end

  // ************************************************************
  // framing
  // ************************************************************
  // start or repeated start: data falls while the clock is high
  task automatic start();
    if (!link_clk) begin
      #(HALF_NS);
      data_in = 1'b1;
      #(HALF_NS);
      link_clk = 1'b1;
    end
    #(HALF_NS);
    data_in = 1'b0;
    #(HALF_NS);
    link_clk = 1'b0;
  endtask : start

  // stop: data rises while the clock is high
  task automatic stop();
    #(HALF_NS);
    data_in = 1'b0;
    #(HALF_NS);
    link_clk = 1'b1;
    #(HALF_NS);
    data_in = 1'b1;
  endtask : stop

  // ************************************************************
  // bits and bytes
  // ************************************************************
  // one clock period; the low phase is stretched so the synchronised answer settles
  task automatic bit_cyc(input logic b, output logic smp);
    #(HALF_NS + HALF_NS / 2);
    data_in = b;
    #(HALF_NS + HALF_NS / 2);
    link_clk = 1'b1;
    smp = data_out;
    #(HALF_NS);
    link_clk = 1'b0;
  endtask : bit_cyc

  // send a byte most significant bit first, release for the slave's acknowledge
  task automatic wr_byte(input logic [7:0] b, output logic ack, output logic [7:0] echo);
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(b[i], echo[i]);
    end
    bit_cyc(1'b1, ack);
  endtask : wr_byte

  // receive a byte with the line held high, then answer with the given acknowledge
  task automatic rd_byte(input logic mack, output logic [7:0] b);
    logic unused;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b1, b[i]);
    end
    bit_cyc(mack, unused);
  endtask : rd_byte
endmodule : link_master

/* tb/tb.sv */
// self-checking bench for the two-wire memory slave port
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int         PCYC   = 20;  // shortened programming time per byte
  localparam logic [7:0] WR_DEV = {eeprom_pkg::DEV_TYPE_DEF, eeprom_pkg::BUS_ADDR, 1'b0};

  logic       clk;
  logic       rst_n;
  logic       link_clk;
  logic       data_in;
  logic       data_out;
  logic       prog_busy;
  int         bad_count;
  int         checks;
  logic [7:0] mem [128];  // expected memory contents
  logic [7:0] got;
  logic [7:0] echo;
  logic       ack;
  logic [6:0] a;
  int         n;

  // ************************************************************
  // clock, design and master
  // ************************************************************
  // system clock at 40 MHz
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  eeprom_serial_port #(
    .DEV_TYPE   (eeprom_pkg::DEV_TYPE_DEF),
    .PROG_CYC   (PCYC),
    .FIFO_DEPTH (eeprom_pkg::FIFO_DEPTH)
  ) dut_u (
    .clk       (clk),
    .rst_n     (rst_n),
    .link_clk  (link_clk),
    .data_in   (data_in),
    .data_out  (data_out),
    .prog_busy (prog_busy)
  );

  link_master #(
    .HALF_NS (80)
  ) master_u (
    .link_clk (link_clk),
    .data_in  (data_in),
    .data_out (data_out)
  );

  // ************************************************************
  // compare and helper tasks
  // ************************************************************
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk1(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk1

  // location of the i-th byte of an access, wrapping inside its 16-byte block
  function automatic logic [6:0] loc(input logic [6:0] base, input int i);
    logic [3:0] low;
    low = base[3:0] + 4'(i);
    return {base[6:4], low};
  endfunction : loc

  // start, write addressing byte, set pointer
  task automatic addr_cmd(input logic [6:0] p);
    master_u.start();
    master_u.wr_byte(WR_DEV, ack, echo);
    chk1(ack, 1'b0);
    chk8(echo, WR_DEV);
    master_u.wr_byte({1'b0, p}, ack, echo);
    chk1(ack, 1'b0);
  endtask : addr_cmd

  // write cnt random bytes and end with stop
  task automatic write_run(input logic [6:0] p, input int cnt);
    logic [7:0] d;
    addr_cmd(p);
    for (int i = 0; i < cnt; i++) begin
      d = 8'($urandom);
      master_u.wr_byte(d, ack, echo);
      chk1(ack, 1'b0);
      chk8(echo, d);
      mem[loc(p, i)] = d;
    end
    // a seventeenth byte in one access is refused
    if (cnt == 16) begin
      master_u.wr_byte(8'($urandom), ack, echo);
      chk1(ack, 1'b1);
    end
    master_u.stop();
    repeat (6) @(posedge clk);
    #2;
    chk1(prog_busy, 1'b1);
  endtask : write_run

  // wait for the programming cycle to end, bounded
  task automatic wait_idle();
    for (int k = 0; k < 2000 && prog_busy !== 1'b0; k++) begin
      @(posedge clk);
    end
    #2;
    chk1(prog_busy, 1'b0);
  endtask : wait_idle

  // set pointer, repeated start, read cnt bytes, last one not acknowledged when cnt is below 16
  task automatic read_run(input logic [6:0] p, input int cnt);
    addr_cmd(p);
    master_u.start();
    master_u.wr_byte(WR_DEV | 8'h01, ack, echo);
    chk1(ack, 1'b0);
    for (int i = 0; i < cnt; i++) begin
      master_u.rd_byte(i == cnt - 1 && cnt < 16, got);
      chk8(got, mem[loc(p, i)]);
    end
    // after a full block the port stops sending and the line reads high
    if (cnt == 16) begin
      master_u.rd_byte(1'b1, got);
      chk8(got, 8'hff);
    end
    master_u.stop();
  endtask : read_run

  // print counts and verdict, end the run
  task automatic wrap_up();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // ************************************************************
  // tests
  // ************************************************************
  // watchdog against a hung handshake
  initial begin
    #1000000;  // well above the longest run of about 0.5 ms
    bad_count++;
    wrap_up();
  end

  // main sequence: reset, refused addressing, random write and read-back runs
  initial begin
    rst_n = 1'b0;
    bad_count = 0;
    checks = 0;
    void'($urandom(37));
    repeat (4) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    chk1(data_out, 1'b1);
    chk1(prog_busy, 1'b0);
    // wrong bus address and wrong type code are not acknowledged
    for (int k = 0; k < 2; k++) begin
      master_u.start();
      master_u.wr_byte(WR_DEV ^ (k == 0 ? 8'h02 : 8'h80), ack, echo);
      chk1(ack, 1'b1);
      master_u.stop();
    end
    for (int it = 0; it < 4; it++) begin
      a = 7'($urandom);
      n = (it == 0) ? 16 : int'($urandom_range(16, 1));
      write_run(a, n);
      if (it == 0) begin
        // a start during programming is ignored
        master_u.start();
        master_u.wr_byte(WR_DEV, ack, echo);
        chk1(ack, 1'b1);
        master_u.stop();
      end
      wait_idle();
      read_run(a, n);
    end
    wrap_up();
  end
endmodule : tb
